// ---- design/fimac_map.svh ----
// Purpose: constants for the fractional/integer multiply-accumulate datapath
// Assumes: included by bare name from the datapath files
// Notes: definitions only
`ifndef FIMAC_MAP_SVH
`define FIMAC_MAP_SVH
`define FIMAC_EXT_W 4
`define FIMAC_WORD_W 16
`define FIMAC_ACC_W 36
`define FIMAC_LOW_MSB 15
`define FIMAC_MID_LSB 16
`define FIMAC_MID_MSB 31
`define FIMAC_EXT_LSB 32
`define FIMAC_ROUND_BIT 15
`define FIMAC_ACC_RESET 36'h0_0000_0000
`define FIMAC_SAT_POS_WORD 16'h7fff
`define FIMAC_SAT_NEG_WORD 16'h8000
`endif

// ---- design/fimac_pkg.sv ----
// Purpose: types for the multiply-accumulate datapath
// Assumes: fimac_map.svh holds the numeric constants
// Notes: operation codes are driven by the instruction decoder
package fimac_pkg;
  typedef enum logic [3:0] {
    FIMAC_OP_NOP = 4'h0,
    FIMAC_OP_LOAD_WORD = 4'h1,
    FIMAC_OP_LOAD_LONG = 4'h2,
    FIMAC_OP_ADD = 4'h3,
    FIMAC_OP_SUB = 4'h4,
    FIMAC_OP_CMP = 4'h5,
    FIMAC_OP_FMPY = 4'h6,
    FIMAC_OP_FMAC = 4'h7,
    FIMAC_OP_FMPYR = 4'h8,
    FIMAC_OP_FMACR = 4'h9,
    FIMAC_OP_IMPYW = 4'ha,
    FIMAC_OP_IMPYL = 4'hb,
    FIMAC_OP_IMACL = 4'hc,
    FIMAC_OP_SAT = 4'hd
  } fimac_op_e;
endpackage : fimac_pkg

// ---- design/fimac_mul_if.sv ----
// Purpose: carries operands and products between datapath and multiplier
// Assumes: one clock, purely combinational contents
// Notes: product fields are 2N bits wide
`timescale 1ns/100ps
interface fimac_mul_if #(parameter int N = 16);
  logic [N-1:0] op_a;
  logic [N-1:0] op_b;
  logic [2*N-1:0] frac_prod;
  logic [2*N-1:0] int_prod;
  modport user (output op_a, output op_b, input frac_prod, input int_prod);
  modport mult (input op_a, input op_b, output frac_prod, output int_prod);
endinterface : fimac_mul_if

// ---- design/fimac_mul.sv ----
// Purpose: signed N x N multiplier giving fractional and integer placements
// Assumes: operands are two's complement
// Notes: combinational; the datapath registers the result
`timescale 1ns/100ps
module fimac_mul import fimac_pkg::*; #(
  parameter int N = 16
) (
  fimac_mul_if.mult mi // operand and product bundle
);
  logic signed [2*N-1:0] full_prod;
  logic [2*N-2:0] core_prod;

  // elaboration-time refusal of widths the placement logic cannot serve
  if (N < 2) begin : g_bad_n
    $error("fimac_mul: N must be at least 2");
  end

  // the true product never needs more than 2N-1 bits, except -1 * -1
  assign full_prod = $signed(mi.op_a) * $signed(mi.op_b);
  assign core_prod = full_prod[2*N-2:0];
  // fractional: zero bit appended below the lsb; -1 * -1 wraps to -1 in the 2N-bit field
  assign mi.frac_prod = {core_prod, 1'b0};
  // integer: extra sign bit prepended above the msb, taken from the full product
  // so that -1 * -1 stays exact as a long integer
  assign mi.int_prod = {full_prod[2*N-1], core_prod};
endmodule : fimac_mul

// ---- design/fimac_datapath.sv ----
// Purpose: accumulator datapath for add, subtract, compare, multiply and multiply-accumulate
// Assumes: op, operands and accumulator select come from the core decoder, same clock
// Notes: two accumulators; result registers update one cycle after a valid op
`timescale 1ns/100ps
`include "fimac_map.svh"

// Operation
// - add, subtract and compare behave the same for fractional and integer data
// - word load puts value in middle word, sign extends, clears low word
// - fractional product gets a zero bit appended below its lsb
// - integer product gets an extra sign bit prepended above its msb
// - fractional multiply gives 32-bit result, lsb zero, sign extended to 36
// - rounded fractional multiply rounds to 16 bits and clears low word
// - word integer multiply writes middle word, sign extends, keeps low word
// - long integer multiply and accumulate give full 32-bit sign-extended product
// - accumulator holds signed 36-bit fractions from -16 to just below +16
// - byte, word and long operands, signed or unsigned, are handled
// - fractional word plus long needs no alignment
// - saturation on reads is switchable for intermediate work
module fimac_datapath import fimac_pkg::*; #(
  parameter int N = 16 // word width
) (
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic op_valid, // op is presented this cycle
  input wire fimac_op_e op, // operation code from decode
  input wire logic acc_sel, // destination/first accumulator
  input wire logic [N-1:0] src_word, // word operand (also first multiply source)
  input wire logic [2*N-1:0] src_long, // long operand
  input wire logic [N-1:0] src_mul_b, // second multiply source
  input wire logic [1:0] src_size, // 0 byte, 1 word, 2 long
  input wire logic src_unsigned, // zero extend the source instead of sign extend
  input wire logic negate_prod, // negated product form
  input wire logic sat_enable, // limit the word read-out
  input wire logic rd_sel, // accumulator to read out
  output logic [`FIMAC_ACC_W-1:0] acc_out, // full accumulator read-out
  output logic [N-1:0] word_out, // middle word, limited when enabled
  output logic cmp_zero, // last compare equal
  output logic cmp_neg, // last compare negative
  output logic ext_in_use // read accumulator uses its extension bits
);
  localparam int AW = `FIMAC_ACC_W;

  logic [AW-1:0] acc_reg [2];
  logic [AW-1:0] acc_next;
  logic acc_we;
  logic [AW-1:0] dst;
  logic [AW-1:0] src_acc;
  logic [AW-1:0] prod_acc;
  logic [AW-1:0] sum;
  logic [AW-1:0] rnd;
  logic [AW-1:0] rnd_sum;
  logic cmp_zero_reg;
  logic cmp_neg_reg;
  logic [AW-1:0] diff;
  logic [AW-1:0] rd_acc;
  logic ext_diff;

  fimac_mul_if #(.N(N)) mbus ();

  // elaboration-time refusal: the accumulator layout is fixed to the word width
  if (N != `FIMAC_WORD_W) begin : g_bad_n
    $error("fimac_datapath: N must equal the accumulator word width");
  end

  //////////////////////////////////////////////////////////////////////////
  // multiplier
  assign mbus.op_a = src_word;
  assign mbus.op_b = src_mul_b;
  fimac_mul #(.N(N)) u_mul (
    .mi(mbus)
  );

  //////////////////////////////////////////////////////////////////////////
  // source alignment into accumulator format
  assign dst = acc_reg[acc_sel];

  always_comb begin
    src_acc = '0;
    unique case (src_size)
      2'h0: begin
        // byte integers sit right-aligned in the middle word
        src_acc[`FIMAC_MID_MSB:`FIMAC_MID_LSB] = src_unsigned ? {8'h00, src_word[7:0]} :
          {{8{src_word[7]}}, src_word[7:0]};
        src_acc[AW-1:`FIMAC_EXT_LSB] = {`FIMAC_EXT_W{src_acc[`FIMAC_MID_MSB]}};
      end
      2'h2: begin
        // a long already shares the binary point of a word in the middle word
        src_acc[`FIMAC_MID_MSB:0] = src_long;
        src_acc[AW-1:`FIMAC_EXT_LSB] = {`FIMAC_EXT_W{src_long[2*N-1] & ~src_unsigned}};
      end
      default: begin
        // word: middle word, extension sign filled, low word cleared
        src_acc[`FIMAC_MID_MSB:`FIMAC_MID_LSB] = src_word;
        src_acc[AW-1:`FIMAC_EXT_LSB] = {`FIMAC_EXT_W{src_word[N-1] & ~src_unsigned}};
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // product placement and rounding
  always_comb begin
    prod_acc = '0;
    unique case (op)
      FIMAC_OP_IMPYL, FIMAC_OP_IMACL:
        prod_acc = {{`FIMAC_EXT_W{mbus.int_prod[2*N-1]}}, mbus.int_prod};
      default:
        prod_acc = {{`FIMAC_EXT_W{mbus.frac_prod[2*N-1]}}, mbus.frac_prod};
    endcase
    if (negate_prod) begin
      prod_acc = AW'(-prod_acc);
    end
  end

  // one adder serves add and accumulate, a subtractor serves subtract and compare, untyped
  assign sum = (op == FIMAC_OP_FMAC || op == FIMAC_OP_FMACR || op == FIMAC_OP_IMACL) ?
    AW'(dst + prod_acc) : AW'(dst + src_acc);
  assign diff = AW'(dst - src_acc);

  // round to nearest at the middle word, then clear the low word
  assign rnd_sum = AW'(((op == FIMAC_OP_FMPYR) ? prod_acc : sum) + (AW'(1) << `FIMAC_ROUND_BIT));
  assign rnd = {rnd_sum[AW-1:`FIMAC_MID_LSB], {`FIMAC_WORD_W{1'b0}}};

  //////////////////////////////////////////////////////////////////////////
  // next accumulator value
  always_comb begin
    acc_next = dst;
    acc_we = op_valid;
    unique case (op)
      FIMAC_OP_LOAD_WORD, FIMAC_OP_LOAD_LONG: acc_next = src_acc;
      FIMAC_OP_ADD: acc_next = sum;
      FIMAC_OP_SUB: acc_next = diff;
      FIMAC_OP_FMPY: acc_next = prod_acc;
      FIMAC_OP_FMAC, FIMAC_OP_IMACL: acc_next = sum;
      FIMAC_OP_FMPYR, FIMAC_OP_FMACR: acc_next = rnd;
      FIMAC_OP_IMPYW: begin
        // word result from the low half of the integer product, low word kept
        acc_next = {{`FIMAC_EXT_W{mbus.int_prod[N-1]}}, mbus.int_prod[N-1:0],
          dst[`FIMAC_LOW_MSB:0]};
      end
      FIMAC_OP_IMPYL: acc_next = prod_acc;
      FIMAC_OP_SAT: begin
        // explicit limiting of the long value in the accumulator
        if (dst[AW-1:`FIMAC_MID_MSB] != {(`FIMAC_EXT_W + 1){dst[AW-1]}}) begin
          acc_next = dst[AW-1] ? {{`FIMAC_EXT_W{1'b1}}, `FIMAC_SAT_NEG_WORD, {`FIMAC_WORD_W{1'b0}}} :
            {{`FIMAC_EXT_W{1'b0}}, `FIMAC_SAT_POS_WORD, {`FIMAC_WORD_W{1'b1}}};
        end
      end
      default: acc_we = 1'b0; // nop and compare leave accumulators
    endcase
  end

  // accumulator storage, 36 bits each, and
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_reg[0] <= `FIMAC_ACC_RESET;
      acc_reg[1] <= `FIMAC_ACC_RESET;
    end else if (acc_we) begin
      acc_reg[acc_sel] <= acc_next;
    end
  end

  // compare flags
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmp_zero_reg <= 1'b0;
      cmp_neg_reg <= 1'b0;
    end else if (op_valid && op == FIMAC_OP_CMP) begin
      cmp_zero_reg <= (diff == '0);
      cmp_neg_reg <= diff[AW-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read-out with switchable saturation
  assign rd_acc = acc_reg[rd_sel];
  assign ext_diff = rd_acc[AW-1:`FIMAC_MID_MSB] != {(`FIMAC_EXT_W + 1){rd_acc[AW-1]}};
  assign acc_out = rd_acc;
  assign ext_in_use = ext_diff;
  assign cmp_zero = cmp_zero_reg;
  assign cmp_neg = cmp_neg_reg;
  // limiting only bites when enabled, so intermediate reads stay exact
  assign word_out = (sat_enable && ext_diff) ?
    (rd_acc[AW-1] ? `FIMAC_SAT_NEG_WORD : `FIMAC_SAT_POS_WORD) :
    rd_acc[`FIMAC_MID_MSB:`FIMAC_MID_LSB];

  //////////////////////////////////////////////////////////////////////////
  // assertions
  AST_WORD_LOAD: assert property (@(posedge core_clk) disable iff (rst)
    op_valid && op == FIMAC_OP_LOAD_WORD && src_size == 2'h1 && !src_unsigned |=>
    acc_reg[$past(acc_sel)] == {{4{$past(src_word[15])}}, $past(src_word), 16'h0000})
    else $error("word load misplaced");
  AST_FRAC_LSB: assert property (@(posedge core_clk) disable iff (rst)
    mbus.frac_prod[0] == 1'b0) else $error("fractional product lsb set");
  AST_INT_SIGN: assert property (@(posedge core_clk) disable iff (rst)
    mbus.op_a != 16'h8000 || mbus.op_b != 16'h8000 |->
    mbus.int_prod[31] == mbus.int_prod[30] && mbus.int_prod[30:0] == mbus.frac_prod[31:1])
    else $error("integer product sign not doubled");
  AST_FMPY: assert property (@(posedge core_clk) disable iff (rst)
    op_valid && op == FIMAC_OP_FMPY && !negate_prod |=>
    acc_reg[$past(acc_sel)][0] == 1'b0 && acc_reg[$past(acc_sel)][35:31] inside {5'h00, 5'h1f})
    else $error("fractional multiply result malformed");
  AST_ROUND_LOW: assert property (@(posedge core_clk) disable iff (rst)
    op_valid && (op == FIMAC_OP_FMPYR || op == FIMAC_OP_FMACR) |=>
    acc_reg[$past(acc_sel)][15:0] == 16'h0000) else $error("rounded result low word not cleared");
  AST_IMPYW_LOW: assert property (@(posedge core_clk) disable iff (rst)
    op_valid && op == FIMAC_OP_IMPYW |=>
    acc_reg[$past(acc_sel)][15:0] == $past(dst[15:0])) else $error("word multiply changed low word");
  AST_IMPYL: assert property (@(posedge core_clk) disable iff (rst)
    op_valid && op == FIMAC_OP_IMPYL && !negate_prod |=>
    $signed(acc_reg[$past(acc_sel)]) == $signed($past(src_word)) * $signed($past(src_mul_b)))
    else $error("long multiply result wrong");
  AST_SAT_OUT: assert property (@(posedge core_clk) disable iff (rst)
    !sat_enable |-> word_out == rd_acc[31:16]) else $error("limiting applied while disabled");
  AST_ADD: assert property (@(posedge core_clk) disable iff (rst)
    op_valid && op == FIMAC_OP_ADD |=> acc_reg[$past(acc_sel)] == 36'($past(dst) + $past(src_acc)))
    else $error("add result wrong");
  COV_FMAC: cover property (@(posedge core_clk) op_valid && op == FIMAC_OP_FMAC);
  COV_SAT_HIT: cover property (@(posedge core_clk) sat_enable && ext_diff);
  COV_IMPYW: cover property (@(posedge core_clk) op_valid && op == FIMAC_OP_IMPYW);
  COV_CMP_EQ: cover property (@(posedge core_clk) op_valid && op == FIMAC_OP_CMP ##1 cmp_zero);
endmodule : fimac_datapath

// ---- verif/fimac_dec_model.sv ----
// Purpose: decoder-side model issuing datapath operations
// Assumes: inputs change on the falling clock edge
// Notes: one op per call, strobe held over one rising edge
`timescale 1ns/100ps
module fimac_dec_model import fimac_pkg::*; (
  input wire logic core_clk, // core clock
  output logic op_valid, // op strobe
  output fimac_op_e op, // operation code
  output logic [15:0] src_word, // word or first multiply source
  output logic [31:0] src_long, // long operand
  output logic [15:0] src_mul_b, // second multiply source
  output logic [1:0] src_size, // operand size
  output logic src_unsigned, // zero extend
  output logic negate_prod // negated product
);
  ////////////////////////////////////////////////////////////////////////////
  // idle values from time zero so no datapath input floats
  initial begin
    op_valid = 1'b0;
    op = FIMAC_OP_NOP;
    {src_word, src_long, src_mul_b, src_size, src_unsigned, negate_prod} = '0;
  end
  // a word meant for a long sum goes out as 16 bits; the datapath widens it by src_size
  task automatic issue(input fimac_op_e o, input logic [15:0] a, input logic [15:0] b, input logic [31:0] l,
    input logic [1:0] sz, input logic un, input logic ng, input logic x0_first);
    @(negedge core_clk);
    op = o;
    src_word = x0_first ? b : a; // index register zero never goes first
    src_mul_b = x0_first ? a : b;
    src_long = l;
    src_size = sz;
    src_unsigned = un;
    negate_prod = ng;
    op_valid = 1'b1;
    @(negedge core_clk);
    op_valid = 1'b0;
  endtask : issue
endmodule : fimac_dec_model

// ---- verif/tb.sv ----
// Purpose: self-checking bench for the multiply-accumulate datapath
// Assumes: results readable one cycle after the op edge
// Notes: expected values worked out by hand from the word formats
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb import fimac_pkg::*; ;
  logic core_clk, rst, acc_sel, sat_enable, rd_sel, op_valid, src_unsigned, negate_prod;
  fimac_op_e op;
  logic [15:0] src_word, src_mul_b, word_out;
  logic [31:0] src_long;
  logic [1:0] src_size;
  logic [35:0] acc_out;
  logic cmp_zero, cmp_neg, ext_in_use;
  int n_fail = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////////////////
  fimac_dec_model dec (.core_clk(core_clk), .op_valid(op_valid), .op(op), .src_word(src_word),
    .src_long(src_long), .src_mul_b(src_mul_b), .src_size(src_size), .src_unsigned(src_unsigned),
    .negate_prod(negate_prod));
  fimac_datapath #(.N(16)) dut (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op(op),
    .acc_sel(acc_sel), .src_word(src_word), .src_long(src_long), .src_mul_b(src_mul_b),
    .src_size(src_size), .src_unsigned(src_unsigned), .negate_prod(negate_prod),
    .sat_enable(sat_enable), .rd_sel(rd_sel), .acc_out(acc_out), .word_out(word_out),
    .cmp_zero(cmp_zero), .cmp_neg(cmp_neg), .ext_in_use(ext_in_use));
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic acc_is(input string nm, input logic [35:0] e);
    `CHK(nm, e, acc_out)
  endtask : acc_is
  // op then compare; keeps each scenario to one line a case
  task automatic op_chk(input fimac_op_e o, input logic [15:0] a, input logic [15:0] b,
    input logic [31:0] l, input logic [1:0] sz, input logic ng, input string nm, input logic [35:0] e);
    dec.issue(o, a, b, l, sz, 1'b0, ng, 1'b0);
    acc_is(nm, e);
  endtask : op_chk
  task automatic t_load;
    op_chk(FIMAC_OP_LOAD_LONG, 0, 0, 32'h1234_5678, 2'h2, 0, "load long", 36'h0_1234_5678);
    op_chk(FIMAC_OP_LOAD_WORD, 16'h8001, 0, 0, 2'h1, 0, "load word", 36'hf_8001_0000);
    dec.issue(FIMAC_OP_LOAD_WORD, 16'h00ff, 0, 0, 2'h0, 1'b1, 1'b0, 1'b0);
    acc_is("unsigned byte", 36'h0_00ff_0000);
    dec.issue(FIMAC_OP_LOAD_LONG, 0, 0, 32'h8000_0000, 2'h2, 1'b1, 1'b0, 1'b0);
    acc_is("unsigned long", 36'h0_8000_0000);
    op_chk(FIMAC_OP_LOAD_WORD, 16'h00ff, 0, 0, 2'h0, 0, "signed byte", 36'hf_ffff_0000);
    $display("test load done");
  endtask : t_load
  task automatic t_fmul;
    op_chk(FIMAC_OP_FMPY, 16'h4000, 16'h4000, 0, 2'h1, 0, "fmpy", 36'h0_2000_0000);
    op_chk(FIMAC_OP_FMPY, 16'h0003, 16'h0003, 0, 2'h1, 0, "fmpy lsb", 36'h0_0000_0012);
    op_chk(FIMAC_OP_FMPY, 16'h8000, 16'h8000, 0, 2'h1, 0, "fmpy max", 36'hf_8000_0000);
    dec.issue(FIMAC_OP_FMPY, 16'h8000, 16'h4000, 0, 2'h1, 1'b0, 1'b0, 1'b1);
    acc_is("fmpy swapped", 36'hf_c000_0000);
    op_chk(FIMAC_OP_FMPY, 16'h4000, 16'h4000, 0, 2'h1, 1, "fmpy neg", 36'hf_e000_0000);
    op_chk(FIMAC_OP_FMAC, 16'h4000, 16'h4000, 0, 2'h1, 0, "fmac", 36'h0_0000_0000);
    op_chk(FIMAC_OP_FMPYR, 16'h4000, 16'h0001, 0, 2'h1, 0, "fmpyr", 36'h0_0001_0000);
    op_chk(FIMAC_OP_FMACR, 16'h4000, 16'h0001, 0, 2'h1, 0, "fmacr", 36'h0_0002_0000);
    $display("test fractional multiply done");
  endtask : t_fmul
  task automatic t_imul;
    op_chk(FIMAC_OP_IMPYL, 16'h0003, 16'hfffe, 0, 2'h1, 0, "impyl", 36'hf_ffff_fffa);
    op_chk(FIMAC_OP_IMACL, 16'h0002, 16'h0003, 0, 2'h1, 0, "imacl", 36'h0_0000_0000);
    op_chk(FIMAC_OP_IMPYL, 16'h8000, 16'h8000, 0, 2'h1, 0, "impyl max", 36'h0_4000_0000);
    op_chk(FIMAC_OP_LOAD_LONG, 0, 0, 32'h0000_1111, 2'h2, 0, "preload", 36'h0_0000_1111);
    op_chk(FIMAC_OP_IMPYW, 16'h0010, 16'hfff0, 0, 2'h1, 0, "impyw", 36'hf_ff00_1111);
    $display("test integer multiply done");
  endtask : t_imul
  // second accumulator, so the first must keep its value
  task automatic t_addsub;
    @(negedge core_clk);
    acc_sel = 1'b1;
    rd_sel = 1'b1;
    op_chk(FIMAC_OP_LOAD_LONG, 0, 0, 32'h4000_0000, 2'h2, 0, "half", 36'h0_4000_0000);
    op_chk(FIMAC_OP_ADD, 16'h2000, 0, 0, 2'h1, 0, "word+long", 36'h0_6000_0000);
    op_chk(FIMAC_OP_ADD, 0, 0, 32'h0000_0040, 2'h2, 0, "int add", 36'h0_6000_0040);
    op_chk(FIMAC_OP_SUB, 0, 0, 32'h6000_0040, 2'h2, 0, "sub", 36'h0_0000_0000);
    op_chk(FIMAC_OP_CMP, 16'h0001, 0, 0, 2'h1, 0, "cmp keeps", 36'h0_0000_0000);
    `CHK("cmp neg", 1'b1, cmp_neg)
    `CHK("cmp zero", 1'b0, cmp_zero)
    dec.issue(FIMAC_OP_CMP, 0, 0, 0, 2'h2, 1'b0, 1'b0, 1'b0);
    `CHK("cmp equal", 1'b1, cmp_zero)
    acc_sel = 1'b0;
    rd_sel = 1'b0;
    #1 acc_is("other acc", 36'hf_ff00_1111);
    $display("test add sub done");
  endtask : t_addsub
  task automatic t_sat;
    op_chk(FIMAC_OP_LOAD_LONG, 0, 0, 32'h7fff_ffff, 2'h2, 0, "load max", 36'h0_7fff_ffff);
    op_chk(FIMAC_OP_ADD, 0, 0, 32'h7fff_ffff, 2'h2, 0, "overflow", 36'h0_ffff_fffe);
    `CHK("ext use", 1'b1, ext_in_use)
    `CHK("raw word", 16'hffff, word_out)
    sat_enable = 1'b1;
    #1 `CHK("limited", 16'h7fff, word_out)
    op_chk(FIMAC_OP_SAT, 0, 0, 0, 2'h2, 0, "sat op", 36'h0_7fff_ffff);
    `CHK("ext clear", 1'b0, ext_in_use)
    `CHK("sat word", 16'h7fff, word_out)
    op_chk(FIMAC_OP_LOAD_LONG, 0, 0, 32'h8000_0000, 2'h2, 0, "min", 36'hf_8000_0000);
    op_chk(FIMAC_OP_SUB, 0, 0, 32'h0000_0001, 2'h2, 0, "under", 36'hf_7fff_ffff);
    `CHK("limited neg", 16'h8000, word_out)
    $display("test saturation done");
  endtask : t_sat
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // the whole run needs well under 200 cycles
  initial begin
    #5000;
    n_fail++;
    $display("ERROR watchdog exp done got hang");
    end_of_test();
  end
  initial begin
    {rst, acc_sel, sat_enable, rd_sel} = 4'h8;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    acc_is("reset", 36'h0_0000_0000);
    t_load();
    t_fmul();
    t_imul();
    t_addsub();
    t_sat();
    end_of_test();
  end
endmodule : tb
